// ---- design/bus_strobe_pkg.sv ----
// Constants and types shared by the local bus strobe logic
package bus_strobe_pkg;

   // ============================================================
   // Bus state machine, one-hot
   // ============================================================
   typedef enum logic [5:0] {
      ST_IDLE  = 6'h01,  // No bus cycle
      ST_ONE   = 6'h02,  // bus_state_one: address
      ST_TWO   = 6'h04,  // bus_state_two: data, strobes begin
      ST_THREE = 6'h08,  // bus_state_three: data, strobes held
      ST_WAIT  = 6'h10,  // bus_wait_state: data, strobes held
      ST_FOUR  = 6'h20   // Last state: data, strobes released
   } bus_state_t;

   // ============================================================
   // Clock phase inside one bus state
   // ============================================================
   localparam logic PHASE_LOW  = 1'b0;  // First half, clock_output low
   localparam logic PHASE_HIGH = 1'b1;  // Second half, clock_output high

   // ============================================================
   // Reset timing, in clk_sys cycles
   // ============================================================
   localparam int          RESET_DRIVE_CYCLES = 1;  // Strobes driven high
   localparam int          SYNC_SETTLE_CYCLES = 4;  // Float plus synchroniser
   localparam logic [2:0]  RST_CNT_RESET      = 3'h0;
   localparam logic [2:0]  RST_CNT_MAX        = 3'h7;
   localparam logic [2:0]  SAMPLE_FROM        =
      3'(RESET_DRIVE_CYCLES + SYNC_SETTLE_CYCLES);

   // ============================================================
   // Byte lane encodings on {byte_high_enable_n, address_bit_zero}
   // ============================================================
   localparam logic [1:0]  LANE_WORD     = 2'h0;  // Both halves
   localparam logic [1:0]  LANE_UPPER    = 2'h1;  // D15..D8 only
   localparam logic [1:0]  LANE_LOWER    = 2'h2;  // D7..D0 only
   localparam logic [1:0]  LANE_RESERVED = 2'h3;  // Never produced

   // ============================================================
   // Queue status codes {queue_status_bit1, queue_status_bit0}
   // ============================================================
   localparam logic [1:0]  QS_NONE     = 2'h0;  // No queue operation
   localparam logic [1:0]  QS_FIRST    = 2'h1;  // First opcode byte taken
   localparam logic [1:0]  QS_EMPTY    = 2'h2;  // Queue emptied
   localparam logic [1:0]  QS_NEXT     = 2'h3;  // Subsequent byte taken

   // ============================================================
   // Values after reset
   // ============================================================
   localparam logic [15:0] DATA_RESET  = 16'h0000;
   localparam logic        MODE_NORMAL = 1'b0;  // Latch, read, write strobes
   localparam logic        MODE_QUEUE  = 1'b1;  // Queue status on pins

endpackage : bus_strobe_pkg

// ---- design/bus_strobe_unit.sv ----
// Local bus strobe, byte lane and queue status pin logic
//
// Contract
// - Encode word, upper or lower byte lanes
// - Address valid before latch strobe falls
// - Latch strobe rises at clock edge before state one
// - Latch strobe falls at clock edge in state one
// - Latch strobe pin is always driven
// - Write strobe low in states two, three, wait
// - Write strobe floats while bus held away, except in queue mode, where the pin keeps driving queue status bit 1
// - Reset drives write high one clock, then floats
// - Queue mode outputs two-bit queue status code
// - Read strobe low from second half of state two, through three, wait
// - Read strobe falls only after address released
// - Read strobe floats while bus held away
// - Reset drives read high one clock, then floats
// - Weak pull-up keeps undriven read pin high
// - Read pin sampled at reset picks mode
// - Address in state one, data afterwards
`timescale 1ns/100ps

module bus_strobe_unit
   import bus_strobe_pkg::*;
#(
   parameter int DATA_W = 16                 // Bus width, multiplexed with address
) (
   input  wire logic              clk_sys,
   input  wire logic              srst,
   // Request side, same clock domain
   input  wire logic              req_valid,
   output logic                   req_ready,
   input  wire logic              req_write,
   input  wire logic              req_byte,
   input  wire logic [DATA_W-1:0] req_addr,
   input  wire logic [DATA_W-1:0] req_wdata,
   input  wire logic              insert_wait,
   input  wire logic              hold_request,
   input  wire logic [1:0]        queue_op,
   output logic [DATA_W-1:0]      rsp_rdata,
   output logic                   rsp_valid,
   output logic                   strobe_mode_queue,
   // Pins
   output logic                   clock_output,
   output logic                   ale_pin,
   output logic                   wr_pin_out,
   output logic                   wr_pin_oe,
   input  wire logic              rd_pin_in,
   output logic                   rd_pin_out,
   output logic                   rd_pin_oe,
   output logic                   rd_pullup_en,
   output logic                   byte_high_enable_n,
   input  wire logic [DATA_W-1:0] ad_in,
   output logic [DATA_W-1:0]      ad_out,
   output logic                   ad_oe
);

   // ============================================================
   // Elaboration check
   // ============================================================
   // Lane logic assumes two byte lanes
   if (DATA_W != 16) begin : g_bad_width
      $error("bus_strobe_unit supports only DATA_W = 16");
   end

   // ============================================================
   // State
   // ============================================================
   bus_state_t        state_reg;          // Current bus state
   bus_state_t        state_next;         // State after this edge
   logic              phase_reg;          // Half of bus state
   logic              phase_next;         // Half after this edge
   logic              pend_reg;           // Request taken, cycle not begun
   logic              pend_next;          // Pending after this edge
   logic              take;               // Request accepted now
   logic              hold_next;          // Bus granted away next
   logic              hold_reg;           // Bus granted away
   logic              cyc_write_reg;      // Current cycle writes
   logic [DATA_W-1:0] cyc_addr_reg;       // Current cycle address
   logic [DATA_W-1:0] cyc_data_reg;       // Current cycle write data
   logic [2:0]        rst_cnt_reg;        // Cycles spent in reset
   logic              rd_sync1_reg;       // Read pin synchroniser stage 1
   logic              rd_sync2_reg;       // Stage 2
   logic              rd_sync3_reg;       // Stage 3
   logic              mode_reg;           // Selected pin mode
   logic              data_phase_next;    // Next state carries data
   logic              strobe_next;        // Next state holds strobes low

   // ============================================================
   // Next bus state
   // ============================================================
   // A bus state spans two clk_sys cycles; states change on the
   // falling clock_output edge, so the rising edge sits mid-state.
   always_comb begin
      take       = req_valid & req_ready;
      state_next = state_reg;
      phase_next = ~phase_reg;
      pend_next  = pend_reg | take;
      if (phase_reg == PHASE_HIGH) begin
         unique case (state_reg)
            ST_IDLE:  state_next = pend_reg ? ST_ONE : ST_IDLE;
            ST_ONE:   state_next = ST_TWO;
            ST_TWO:   state_next = ST_THREE;
            ST_THREE: state_next = insert_wait ? ST_WAIT : ST_FOUR;
            ST_WAIT:  state_next = insert_wait ? ST_WAIT : ST_FOUR;
            ST_FOUR:  state_next = pend_reg ? ST_ONE : ST_IDLE;
         endcase
      end
      if (state_next == ST_ONE) begin
         pend_next = 1'b0;
      end
   end

   // Helper terms on the next state
   always_comb begin
      data_phase_next = (state_next == ST_TWO) || (state_next == ST_THREE) ||
                        (state_next == ST_WAIT) || (state_next == ST_FOUR);
      strobe_next     = (state_next == ST_TWO) || (state_next == ST_THREE) ||
                        (state_next == ST_WAIT);
      // Hold is honoured only between cycles, never inside one
      hold_next       = hold_request && (state_next == ST_IDLE) && !pend_next;
   end

   // ============================================================
   // State registers
   // ============================================================
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         state_reg <= ST_IDLE;
         phase_reg <= PHASE_LOW;
         pend_reg  <= 1'b0;
         hold_reg  <= 1'b0;
      end else begin
         state_reg <= state_next;
         phase_reg <= phase_next;
         pend_reg  <= pend_next;
         hold_reg  <= hold_next;
      end
   end

   // Output clock follows the phase, low in the first half
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         clock_output <= PHASE_LOW;
      end else begin
         clock_output <= phase_next;
      end
   end

   // ============================================================
   // Request acceptance and capture
   // ============================================================
   // Ready only in the low half of an idle or last state, so the
   // latch strobe can still rise on the coming clock_output edge.
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         req_ready <= 1'b0;
      end else begin
         req_ready <= ((state_next == ST_IDLE) || (state_next == ST_FOUR)) &&
                      (phase_next == PHASE_LOW) && !pend_next && !hold_next;
      end
   end

   // Cycle attributes are held from acceptance until the next request is taken
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         cyc_write_reg      <= 1'b0;
         cyc_addr_reg       <= DATA_RESET;
         cyc_data_reg       <= DATA_RESET;
         byte_high_enable_n <= LANE_RESERVED[1];
      end else if (take) begin
         cyc_write_reg      <= req_write;
         cyc_addr_reg       <= req_addr;
         cyc_data_reg       <= req_wdata;
         // Word at odd address goes out as upper byte, never reserved
         byte_high_enable_n <= req_byte & ~req_addr[0];
      end
   end

   // ============================================================
   // Multiplexed address and data bus
   // ============================================================
   // Address from the start of state one, before the latch strobe
   // falls mid-state; reads release the bus at state two.
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         ad_out <= DATA_RESET;
         ad_oe  <= 1'b0;
      end else if (state_next == ST_ONE) begin
         ad_out <= cyc_addr_reg;
         ad_oe  <= 1'b1;
      end else if (data_phase_next && cyc_write_reg) begin
         ad_out <= cyc_data_reg;
         ad_oe  <= 1'b1;
      end else begin
         ad_out <= ad_out;
         ad_oe  <= 1'b0;
      end
   end

   // Read data taken at the close of the final strobe state.
   // The bus is sampled synchronously here, as memory holds it stable.
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         rsp_rdata <= DATA_RESET;
         rsp_valid <= 1'b0;
      end else begin
         rsp_valid <= 1'b0;
         if (!cyc_write_reg && (phase_reg == PHASE_HIGH) && !insert_wait &&
             ((state_reg == ST_THREE) || (state_reg == ST_WAIT))) begin
            rsp_rdata <= ad_in;
            rsp_valid <= 1'b1;
         end
      end
   end

   // ============================================================
   // Reset sequencing and mode strap
   // ============================================================
   // Counts reset cycles; saturates so long resets are harmless
   always_ff @(posedge clk_sys) begin
      if (!srst) begin
         rst_cnt_reg <= RST_CNT_RESET;
      end else if (rst_cnt_reg != RST_CNT_MAX) begin
         rst_cnt_reg <= rst_cnt_reg + 3'h1;
      end
   end

   // Read pin crosses into clk_sys through three flops
   always_ff @(posedge clk_sys) begin
      rd_sync1_reg <= rd_pin_in;
      rd_sync2_reg <= rd_sync1_reg;
      rd_sync3_reg <= rd_sync2_reg;
   end

   // Strap is read only in reset, after the drive cycle and settling;
   // a floating pin rests high on the pull-up and gives normal mode.
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         if (rst_cnt_reg == RST_CNT_RESET) begin
            mode_reg <= MODE_NORMAL;
         end else if ((rst_cnt_reg >= SAMPLE_FROM) && (rd_sync2_reg == rd_sync3_reg)) begin
            mode_reg <= rd_sync3_reg ? MODE_NORMAL : MODE_QUEUE;
         end
      end else begin
         mode_reg <= mode_reg;
      end
   end

   // Mode shown to the rest of the device
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         strobe_mode_queue <= MODE_NORMAL;
      end else begin
         strobe_mode_queue <= mode_reg;
      end
   end

   // Pull-up is always on; the driver overrides it when enabled
   always_ff @(posedge clk_sys) begin
      rd_pullup_en <= 1'b1;
   end

   // ============================================================
   // Latch strobe pin, doubling as queue status bit 0
   // ============================================================
   // Driven in every cycle and mode; it has no enable at all.
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         ale_pin <= 1'b0;
      end else if (mode_reg == MODE_QUEUE) begin
         ale_pin <= queue_op[0];
      end else if (state_next == ST_ONE) begin
         ale_pin <= phase_next == PHASE_LOW;
      end else begin
         // High from the rising edge before state one
         ale_pin <= pend_next && (phase_next == PHASE_HIGH);
      end
   end

   // ============================================================
   // Write strobe pin, doubling as queue status bit 1
   // ============================================================
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         // One driven-high clock, then float
         wr_pin_out <= 1'b1;
         wr_pin_oe  <= rst_cnt_reg < 3'(RESET_DRIVE_CYCLES);
      end else if (mode_reg == MODE_QUEUE) begin
         wr_pin_out <= queue_op[1];
         wr_pin_oe  <= 1'b1;
      end else if (hold_next) begin
         wr_pin_out <= 1'b1;
         wr_pin_oe  <= 1'b0;
      end else begin
         wr_pin_out <= !(strobe_next && cyc_write_reg);
         wr_pin_oe  <= 1'b1;
      end
   end

   // ============================================================
   // Read strobe pin, also the mode strap input
   // ============================================================
   // Falls in the second half of state two, one clk_sys after the
   // address driver lets go, so the two never overlap.
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         rd_pin_out <= 1'b1;
         rd_pin_oe  <= rst_cnt_reg < 3'(RESET_DRIVE_CYCLES);
      end else if (mode_reg == MODE_QUEUE) begin
         // Strap stays grounded outside; never fight it
         rd_pin_out <= 1'b1;
         rd_pin_oe  <= 1'b0;
      end else if (hold_next) begin
         rd_pin_out <= 1'b1;
         rd_pin_oe  <= 1'b0;
      end else begin
         rd_pin_out <= !(strobe_next && !cyc_write_reg &&
                         !((state_next == ST_TWO) && (phase_next == PHASE_LOW)));
         rd_pin_oe  <= 1'b1;
      end
   end

endmodule : bus_strobe_unit

// ---- tb/bus_strobe_chk.sv ----
// Assertion checker for the bus strobe unit pins
`timescale 1ns/100ps
module bus_strobe_chk
   import bus_strobe_pkg::*;
#(
   parameter int DATA_W = 16  // Bus width
) (
   input wire logic              clk_sys,
   input wire logic              srst,
   input wire logic              req_valid,
   input wire logic              req_ready,
   input wire logic              req_write,
   input wire logic              req_byte,
   input wire logic [DATA_W-1:0] req_addr,
   input wire logic              insert_wait,
   input wire logic              hold_request,
   input wire logic [1:0]        queue_op,
   input wire logic              rsp_valid,
   input wire logic              strobe_mode_queue,
   input wire logic              clock_output,
   input wire logic              ale_pin,
   input wire logic              wr_pin_out,
   input wire logic              wr_pin_oe,
   input wire logic              rd_pin_out,
   input wire logic              rd_pin_oe,
   input wire logic              byte_high_enable_n,
   input wire logic [DATA_W-1:0] ad_out,
   input wire logic              ad_oe
);
   // ============================================================
   // Request taken, and taken while in strobe mode
   wire take = req_valid && req_ready;
   wire norm = take && !strobe_mode_queue;
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (srst);
   property p_lane; take |=> byte_high_enable_n == $past(req_byte && !req_addr[0]); endproperty
   a_lane: assert property (p_lane) else $error("lane enable wrong");
   property p_addr; take |=> ##1 (ad_oe && ad_out == $past(req_addr, 2)); endproperty
   a_addr: assert property (p_addr) else $error("address not on bus");
   property p_valid; $fell(ale_pin) && !strobe_mode_queue |-> ad_oe && $stable(ad_out); endproperty
   a_valid: assert property (p_valid) else $error("address moved at latch");
   property p_rise; norm && !ale_pin |=> ale_pin && clock_output; endproperty
   a_rise: assert property (p_rise) else $error("latch strobe late");
   property p_fall; norm |=> ##1 (ale_pin && !clock_output) ##1 (!ale_pin && clock_output); endproperty
   a_fall: assert property (p_fall) else $error("latch strobe fall wrong");
   property p_wr; norm && req_write |=> ##3 (!wr_pin_out && wr_pin_oe && ad_oe)[*4]; endproperty
   a_wr: assert property (p_wr) else $error("write strobe wrong");
   property p_rd;
      norm && !req_write |=> ##3 (rd_pin_out && !ad_oe) ##1 (!rd_pin_out && rd_pin_oe)[*3];
   endproperty
   a_rd: assert property (p_rd) else $error("read strobe wrong");
   property p_hold;
      (hold_request && !insert_wait)[*8] ##1 hold_request[*3]
         |-> !rd_pin_oe && (strobe_mode_queue || !wr_pin_oe);
   endproperty
   a_hold: assert property (p_hold) else $error("strobe driven in hold");
   property p_reset;
      disable iff (1'b0) srst && !$past(srst) ##1 srst
         |-> (rd_pin_oe && rd_pin_out && wr_pin_oe && wr_pin_out) ##1 (!rd_pin_oe && !wr_pin_oe);
   endproperty
   a_reset: assert property (p_reset) else $error("reset strobe drive wrong");
   property p_queue;
      strobe_mode_queue && !$past(srst) |-> wr_pin_oe && {wr_pin_out, ale_pin} == $past(queue_op);
   endproperty
   a_queue: assert property (p_queue) else $error("queue code wrong");
   // The mode output takes its strapped value on the first edge out of reset
   property p_mode;
      !$past(srst) && !$past(srst, 2) |-> $stable(strobe_mode_queue);
   endproperty
   a_mode: assert property (p_mode) else $error("mode changed");
   // Main scenarios reached
   c_read: cover property (norm && !req_write);
   c_write: cover property (norm && req_write);
   c_empty: cover property (strobe_mode_queue && queue_op == QS_EMPTY);
endmodule : bus_strobe_chk

bind bus_strobe_unit bus_strobe_chk #(.DATA_W(DATA_W)) u_chk (
   .clk_sys(clk_sys), .srst(srst), .req_valid(req_valid), .req_ready(req_ready),
   .req_write(req_write), .req_byte(req_byte), .req_addr(req_addr),
   .insert_wait(insert_wait), .hold_request(hold_request), .queue_op(queue_op),
   .rsp_valid(rsp_valid), .strobe_mode_queue(strobe_mode_queue),
   .clock_output(clock_output), .ale_pin(ale_pin), .wr_pin_out(wr_pin_out),
   .wr_pin_oe(wr_pin_oe), .rd_pin_out(rd_pin_out), .rd_pin_oe(rd_pin_oe),
   .byte_high_enable_n(byte_high_enable_n), .ad_out(ad_out), .ad_oe(ad_oe)
);

// ---- tb/bus_far_side.sv ----
// Far-side model: address latch, banked memory and read pin strap
`timescale 1ns/100ps
module bus_far_side (
   input  wire logic        clk_sys,
   input  wire logic        strap_low,  // Read pin tied to ground
   input  wire logic        ale_pin,
   input  wire logic        byte_high_enable_n,
   input  wire logic        rd_pin_out,
   input  wire logic        rd_pin_oe,
   input  wire logic        wr_pin_out,
   input  wire logic        wr_pin_oe,
   input  wire logic [15:0] ad_out,
   output logic             rd_wire,    // Resolved read pin level
   output logic [15:0]      ad_in,
   output logic             wr_seen,    // Pulse after a write strobe ends
   output logic [15:0]      wr_word
);
   logic [15:0] addr_latch;             // Taken as the latch strobe falls
   logic [15:0] junk = 16'h1234;        // Undriven bus, changes every cycle
   logic        wr_q = 1'b1;
   // Ground wins; weak pull-up when nobody drives
   assign rd_wire = strap_low ? 1'b0 : (rd_pin_oe ? rd_pin_out : 1'b1);
   // Only the enabled banks answer a read
   assign ad_in = (!rd_wire && !strap_low) ?
      {byte_high_enable_n ? junk[15:8] : addr_latch[15:8] ^ 8'h5a,
       addr_latch[0] ? junk[7:0] : addr_latch[7:0] ^ 8'h3c} : junk;
   always @(negedge ale_pin) addr_latch = ad_out;
   // Store on the strobe's rising edge
   always @(posedge clk_sys) begin
      junk    <= ~junk;
      wr_q    <= wr_pin_out | !wr_pin_oe | strap_low;
      wr_seen <= !wr_q && wr_pin_out && wr_pin_oe && !strap_low;
      wr_word <= ad_out;
   end
endmodule : bus_far_side

// ---- tb/test_local_bus_strobes_queue_status.sv ----
// Self-checking bench for the bus strobe unit
`timescale 1ns/100ps
module test_local_bus_strobes_queue_status;
   import bus_strobe_pkg::*;
   logic        clk_sys, srst, req_valid, req_write, req_byte, insert_wait;
   logic        hold_request, strap_low, req_ready, rsp_valid, strobe_mode_queue;
   logic        clock_output, ale_pin, wr_pin_out, wr_pin_oe, rd_pin_out, rd_pin_oe;
   logic        rd_pullup_en, byte_high_enable_n, ad_oe, rd_wire, wr_seen;
   logic [15:0] req_addr, req_wdata, rsp_rdata, ad_out, ad_in, wr_word;
   logic [1:0]  queue_op;
   logic [31:0] rd_exp[$], wr_exp[$];   // Notes of {lane mask, value}
   logic [31:0] e;
   int          error_cnt, tests_run, cycles, seed, r;
   bus_strobe_unit #(.DATA_W(16)) dut (.clk_sys(clk_sys), .srst(srst), .req_valid(req_valid),
      .req_ready(req_ready), .req_write(req_write), .req_byte(req_byte), .req_addr(req_addr),
      .req_wdata(req_wdata), .insert_wait(insert_wait), .hold_request(hold_request),
      .queue_op(queue_op), .rsp_rdata(rsp_rdata), .rsp_valid(rsp_valid),
      .strobe_mode_queue(strobe_mode_queue), .clock_output(clock_output), .ale_pin(ale_pin),
      .wr_pin_out(wr_pin_out), .wr_pin_oe(wr_pin_oe), .rd_pin_in(rd_wire),
      .rd_pin_out(rd_pin_out), .rd_pin_oe(rd_pin_oe), .rd_pullup_en(rd_pullup_en),
      .byte_high_enable_n(byte_high_enable_n), .ad_in(ad_in), .ad_out(ad_out), .ad_oe(ad_oe));
   bus_far_side far (.clk_sys(clk_sys), .strap_low(strap_low), .ale_pin(ale_pin),
      .byte_high_enable_n(byte_high_enable_n), .rd_pin_out(rd_pin_out), .rd_pin_oe(rd_pin_oe),
      .wr_pin_out(wr_pin_out), .wr_pin_oe(wr_pin_oe), .ad_out(ad_out), .rd_wire(rd_wire),
      .ad_in(ad_in), .wr_seen(wr_seen), .wr_word(wr_word));
   initial begin
      clk_sys = 1'b0;
      forever #20 clk_sys = ~clk_sys;
   end
   task automatic check_word(input string what, input logic [15:0] exp, got);
      tests_run++;
      if (got !== exp) begin
         error_cnt++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask : check_word
   task automatic check_bit(input string what, input logic exp, got);
      check_word(what, {15'h0, exp}, {15'h0, got});
   endtask : check_bit
   task automatic wrap_up;
      if (error_cnt == 0 && tests_run > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : wrap_up
   // Reset held long enough for the strap to settle
   task automatic do_reset(input logic low);
      @(negedge clk_sys);
      strap_low = low;
      srst = 1'b1;
      repeat (3) @(negedge clk_sys);
      check_bit("read enable in reset", 1'b0, rd_pin_oe);
      check_bit("write enable in reset", 1'b0, wr_pin_oe);
      repeat (5) @(negedge clk_sys);
      srst = 1'b0;
      repeat (3) @(negedge clk_sys);
      check_bit("queue mode", low, strobe_mode_queue);
      check_bit("read pull-up", 1'b1, rd_pullup_en);
   endtask : do_reset
   // One transfer; the note is queued as it is taken
   task automatic bus_op(input logic wr, byt, input logic [15:0] a, d, input logic wt);
      logic [15:0] m;
      int          n;
      m = a[0] ? 16'hff00 : (byt ? 16'h00ff : 16'hffff);
      @(negedge clk_sys);
      req_valid = 1'b1;
      req_write = wr;
      req_byte = byt;
      req_addr = a;
      req_wdata = d;
      n = 0;
      while (req_ready !== 1'b1 && n < 50) begin
         @(negedge clk_sys);
         n++;
      end
      check_bit("ready", 1'b1, req_ready);
      if (wr) wr_exp.push_back({m, d & m});
      else rd_exp.push_back({m, (a ^ 16'h5a3c) & m});
      @(negedge clk_sys);
      req_valid = 1'b0;
      if (wt) begin
         // Must stand at the edge closing the high half of state three
         repeat (6) @(negedge clk_sys);
         insert_wait = 1'b1;
         @(negedge clk_sys);
         insert_wait = 1'b0;
      end
   endtask : bus_op
   // Oldest note against each result as it shows
   always @(negedge clk_sys) begin
      if (rsp_valid === 1'b1) begin
         e = rd_exp.size() ? rd_exp.pop_front() : 32'hx;
         check_word("read data", e[15:0], rsp_rdata & e[31:16]);
      end
      if (wr_seen === 1'b1) begin
         e = wr_exp.size() ? wr_exp.pop_front() : 32'hx;
         check_word("write data", e[15:0], wr_word & e[31:16]);
      end
   end
   always @(posedge clk_sys) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         error_cnt++;
         wrap_up();
      end
   end
   initial begin
      srst = 1'b1;
      {req_valid, req_write, req_byte, insert_wait, hold_request, strap_low} = 6'h0;
      req_addr = 16'h0;
      req_wdata = 16'h0;
      queue_op = 2'h0;
      {error_cnt, tests_run, cycles, seed} = {32'd0, 32'd0, 32'd0, 32'd4};
      // Reset cycle counter clears only outside reset: one free edge first
      repeat (4) @(negedge clk_sys);
      srst = 1'b0;
      do_reset(1'b0);
      for (int i = 0; i < 8; i++) begin
         bus_op(i[2], i[1], {15'h2b4c, i[0]}, 16'hc3a5 ^ 16'(i), 1'b0);
      end
      bus_op(1'b0, 1'b0, 16'h8001, 16'h0, 1'b1);
      for (int n = 0; n < 24; n++) begin
         r = $random(seed);
         bus_op(r[0], r[1], r[17:2], 16'($random(seed)), r[18] & r[19]);
      end
      // Bus granted away between cycles
      repeat (12) @(negedge clk_sys);
      hold_request = 1'b1;
      repeat (14) @(negedge clk_sys);
      check_bit("read enable in hold", 1'b0, rd_pin_oe);
      check_bit("write enable in hold", 1'b0, wr_pin_oe);
      hold_request = 1'b0;
      bus_op(1'b0, 1'b1, 16'h0f0f, 16'h0, 1'b0);
      repeat (20) @(negedge clk_sys);
      check_word("pending", 16'h0, 16'(rd_exp.size() + wr_exp.size()));
      do_reset(1'b1);
      for (int c = 0; c < 4; c++) begin
         queue_op = 2'(c);
         @(negedge clk_sys);
         check_bit("queue bit1", queue_op[1], wr_pin_out);
         check_bit("queue bit0", queue_op[0], ale_pin);
      end
      strap_low = 1'b0;
      repeat (10) @(negedge clk_sys);
      check_bit("mode kept", 1'b1, strobe_mode_queue);
      wrap_up();
   end
endmodule : test_local_bus_strobes_queue_status
